// [vcic_pkg.sv]
package vcic_pkg;

  // ***********************************
  // register map
  // ***********************************
  localparam logic [15:0] VCIC_OFS_TYPE  = 16'h0004;
  localparam logic [15:0] VCIC_OFS_VMC   = 16'h0008;
  localparam logic [15:0] VCIC_OFS_MAINT = 16'h0010;

  // ***********************************
  // sizes and field layout
  // ***********************************
  localparam int VCIC_LIST_N   = 4;
  localparam int VCIC_PRIO_W   = 5;
  localparam int VCIC_ID_W     = 10;
  localparam int VCIC_GRP_W    = 3;
  localparam int VCIC_MASK_W   = 8;
  localparam int VCIC_MAINT_W  = 8;
  localparam int VCIC_COUNT_W  = 5;
  localparam int VCIC_EOIF_BIT = 0;

  // list entry state codes
  localparam logic [1:0] VCIC_ST_INACTIVE = 2'h0;
  localparam logic [1:0] VCIC_ST_PENDING  = 2'h1;
  localparam logic [1:0] VCIC_ST_ACTIVE   = 2'h2;
  localparam logic [1:0] VCIC_ST_ACT_PEND = 2'h3;

  // identifier returned for a hidden group 1 interrupt
  localparam logic [9:0] VCIC_ID_SPURIOUS_G1 = 10'h3FE;

  // type register contents
  localparam logic [2:0] VCIC_PRIO_BITS_M1 = 3'h4;
  localparam logic [2:0] VCIC_PREE_BITS_M1 = 3'h4;
  localparam logic [2:0] VCIC_IDW_16       = 3'h0;
  localparam logic [2:0] VCIC_IDW_24       = 3'h1;
  localparam logic       VCIC_SYSERR_SUPP  = 1'b0;
  localparam logic       VCIC_TOPAFF_VALID = 1'b0;
  localparam logic [4:0] VCIC_LIST_M1      = 5'h3;

  localparam logic [31:0] VCIC_ZERO32 = 32'h0000_0000;
  localparam logic [7:0]  VCIC_ZERO8  = 8'h00;

  // ***********************************
  // carriers
  // ***********************************
  typedef struct packed {
    logic [7:0] prio_mask;
    logic [2:0] bp0;
    logic [2:0] bp1;
    logic [7:0] rsv_hi;
    logic       eoi_mode;
    logic [3:0] rsv_lo;
    logic       cbpr;
    logic       fiq_en;
    logic       ack_ctl;
    logic       grp1_en;
    logic       grp0_en;
  } vcic_vmc_t;

  typedef struct packed {
    logic [2:0]  prio_bits;
    logic [2:0]  pree_bits;
    logic [2:0]  id_bits;
    logic        sys_err;
    logic        top_aff;
    logic [15:0] rsv;
    logic [4:0]  list_m1;
  } vcic_type_t;

  typedef struct packed {
    logic [1:0] state;
    logic       group;
    logic [4:0] prio;
    logic [9:0] id;
  } vcic_entry_t;

  // guest-side field update strobes and data
  typedef struct packed {
    logic       pmr_we;
    logic [7:0] pmr;
    logic       bpr_we;
    logic [2:0] bpr;
    logic       abpr_we;
    logic [2:0] abpr;
    logic       ctl_we;
    logic       eoi_mode;
    logic       cbpr;
    logic       fiq_en;
    logic       ack_ctl;
    logic       grp1_en;
    logic       grp0_en;
  } vcic_guest_t;

  typedef enum logic [1:0] {
    VCIC_BUS_IDLE = 2'b00,
    VCIC_BUS_RESP = 2'b01
  } vcic_bus_st_t;

endpackage : vcic_pkg

// [vcic_ctrl.sv]
`timescale 1ns/1ps
// Operation
// R1: maintenance eoi flag is one exactly when any eoi status bit is one
// R2: maintenance flags reset to zero
// R3: only entries in plain pending state count as pending
// R4: maintenance status readable at offset 0x0010
// R5: guest writes to interface fields update the matching alias fields
// R6: eight-bit priority mask in top byte; signal only higher priority
// R7: group 0 binary point splits priority for group 0, group 1 if common
// R8: group 1 binary point used for group 1 when common bit zero
// R9: eoi mode zero drops and deactivates; one needs separate deactivate
// R10: common bit selects group 1 binary point source
// R11: group 0 signalled as fast interrupt when fast enable set
// R12: group 1 highest pending reads 1022 unless acknowledge control set
// R13: each group signalled only while its enable bit is one
// R14: control fields may reset unknown; reserved ranges read zero
// R15: virtual machine control readable and writable at offset 0x0008
// R16: type top bits report priority bits minus one, at least five
// R17: preemption bits minus one, at least five, not above priority bits
// R18: identifier width code 000 for 16 bits, 001 for 24
// R19: report system error support and top affinity support bits
// R20: low five type bits report list entries minus one
// R21: type register readable at offset 0x0004
// R22: software uses these registers only when system access disabled
// R23: maintenance interrupt needs a status bit set and control enable
// R24: entry state codes inactive, pending, active, active and pending
// R25: writes to read-only registers are ignored
module vcic_ctrl
  import vcic_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // memory-mapped register port
  input  wire logic                     reg_sel_i,
  input  wire logic                     reg_wr_i,
  input  wire logic [15:0]              reg_addr_i,
  input  wire logic [31:0]              reg_wdata_i,
  output logic      [31:0]              reg_rdata_o,
  output logic                          reg_ack_o,
  // guest interface alias updates
  input  wire vcic_pkg::vcic_guest_t    guest_i,
  input  wire logic                     guest_eoi_i,
  input  wire logic                     guest_dir_i,
  input  wire logic [9:0]               guest_intid_i,
  // list entries and hypervisor state
  input  wire vcic_pkg::vcic_entry_t    entry_i [vcic_pkg::VCIC_LIST_N],
  input  wire logic [vcic_pkg::VCIC_LIST_N-1:0] eoi_status_i,
  input  wire logic [7:1]               maint_other_i,
  input  wire logic                     hyp_enable_i,
  input  wire logic [4:0]               running_prio_i,
  // outputs toward the processing element
  output logic                          virq_o,
  output logic                          vfiq_o,
  output logic      [9:0]               hp_intid_o,
  output logic                          hp_valid_o,
  output logic                          prio_drop_o,
  output logic                          deactivate_o,
  output logic      [9:0]               deact_intid_o,
  output logic                          maint_irq_o,
  output logic      [vcic_pkg::VCIC_LIST_N-1:0] pending_map_o
);
  import vcic_pkg::*;

  // ***********************************
  // state
  // ***********************************
  vcic_vmc_t           vmc;
  logic [7:0]          maint;
  vcic_bus_st_t        bus_st;

  // ***********************************
  // decode
  // ***********************************
  wire logic hit_type  = reg_addr_i == VCIC_OFS_TYPE;
  wire logic hit_vmc   = reg_addr_i == VCIC_OFS_VMC;
  wire logic hit_maint = reg_addr_i == VCIC_OFS_MAINT;
  wire logic bus_go    = reg_sel_i && (bus_st == VCIC_BUS_IDLE);
  wire logic vmc_bus_we = bus_go && reg_wr_i && hit_vmc; // R15 R25
  // bus write word viewed through the control layout, no bare bit positions
  wire vcic_vmc_t bus_vmc = vcic_vmc_t'(reg_wdata_i);

  wire vcic_type_t type_val = '{
    prio_bits: VCIC_PRIO_BITS_M1,   // R16
    pree_bits: VCIC_PREE_BITS_M1,   // R17
    id_bits:   VCIC_IDW_16,         // R18
    sys_err:   VCIC_SYSERR_SUPP,    // R19
    top_aff:   VCIC_TOPAFF_VALID,   // R19
    rsv:       16'h0000,
    list_m1:   VCIC_LIST_M1         // R20
  };

  wire logic [31:0] vmc_view = {vmc.prio_mask, vmc.bp0, vmc.bp1, VCIC_ZERO8,
                                vmc.eoi_mode, 4'h0, vmc.cbpr, vmc.fiq_en,
                                vmc.ack_ctl, vmc.grp1_en, vmc.grp0_en}; // R14

  wire logic [31:0] rd_mux = hit_type  ? type_val :            // R21
                             hit_vmc   ? vmc_view :            // R15
                             hit_maint ? {24'h000000, maint} : // R4
                             VCIC_ZERO32;

  // ***********************************
  // pending scan
  // ***********************************
  logic [VCIC_LIST_N-1:0] pend;
  logic [VCIC_LIST_N-1:0] elig;
  genvar g;
  generate
    for (g = 0; g < VCIC_LIST_N; g++)
    begin : g_scan
      // R3 R24: active and pending does not count
      assign pend[g] = entry_i[g].state == VCIC_ST_PENDING;
      // R6 R13: lower value is higher priority; mask is 8-bit aligned to msb
      assign elig[g] = pend[g]
                       && ({entry_i[g].prio, 3'h0} < vmc.prio_mask)
                       && (entry_i[g].group ? vmc.grp1_en : vmc.grp0_en);
    end
  endgenerate

  // ***********************************
  // highest priority select
  // ***********************************
  logic       best_v;
  logic [4:0] best_p;
  logic [9:0] best_id;
  logic       best_g;
  always_comb
  begin
    best_v  = 1'b0;
    best_p  = 5'h1F;
    best_id = 10'h000;
    best_g  = 1'b0;
    for (int i = 0; i < VCIC_LIST_N; i++)
    begin
      if (elig[i] && (!best_v || entry_i[i].prio < best_p))
      begin
        best_v  = 1'b1;
        best_p  = entry_i[i].prio;
        best_id = entry_i[i].id;
        best_g  = entry_i[i].group;
      end
    end
  end

  // R7 R8 R10: group priority from the binary point of the governing group
  wire logic [2:0] bp_sel = (best_g && !vmc.cbpr) ? vmc.bp1 : vmc.bp0;
  wire logic [7:0] gmask  = 8'hFE << bp_sel;
  wire logic [7:0] best_gp = {best_p, 3'h0} & gmask;
  wire logic [7:0] run_gp  = {running_prio_i, 3'h0} & gmask;
  wire logic preempt = best_v && (best_gp < run_gp);

  // R11: group 0 goes out on the fast line only when selected
  wire logic next_vfiq = preempt && !best_g && vmc.fiq_en;
  wire logic next_virq = preempt && !(!best_g && vmc.fiq_en);
  // R12: group 1 identity hidden unless acknowledge control set
  wire logic [9:0] next_hp = (best_g && !vmc.ack_ctl) ? VCIC_ID_SPURIOUS_G1 : best_id;

  // R1: eoi flag follows eoi status directly
  wire logic [7:0] next_maint = {maint_other_i, |eoi_status_i};
  // R9: deactivation by eoi only in mode zero, else by explicit write
  wire logic next_deact = (guest_eoi_i && !vmc.eoi_mode) || (guest_dir_i && vmc.eoi_mode);

  // ***********************************
  // registers
  // ***********************************
  // R14: alias fields carry no reset; software restores them
  always_ff @(posedge clk_i)
  begin
    if (guest_i.pmr_we)
      vmc.prio_mask <= guest_i.pmr;          // R5 R6
    else if (vmc_bus_we)
      vmc.prio_mask <= bus_vmc.prio_mask;
    if (guest_i.bpr_we)
      vmc.bp0 <= guest_i.bpr;                // R5
    else if (vmc_bus_we)
      vmc.bp0 <= bus_vmc.bp0;
    if (guest_i.abpr_we)
      vmc.bp1 <= guest_i.abpr;               // R5
    else if (vmc_bus_we)
      vmc.bp1 <= bus_vmc.bp1;
    if (guest_i.ctl_we)
    begin
      vmc.eoi_mode <= guest_i.eoi_mode;      // R5
      vmc.cbpr     <= guest_i.cbpr;
      vmc.fiq_en   <= guest_i.fiq_en;
      vmc.ack_ctl  <= guest_i.ack_ctl;
      vmc.grp1_en  <= guest_i.grp1_en;
      vmc.grp0_en  <= guest_i.grp0_en;
    end
    else if (vmc_bus_we)
    begin
      vmc.eoi_mode <= bus_vmc.eoi_mode;
      vmc.cbpr     <= bus_vmc.cbpr;
      vmc.fiq_en   <= bus_vmc.fiq_en;
      vmc.ack_ctl  <= bus_vmc.ack_ctl;
      vmc.grp1_en  <= bus_vmc.grp1_en;
      vmc.grp0_en  <= bus_vmc.grp0_en;
    end
    vmc.rsv_hi <= VCIC_ZERO8;
    vmc.rsv_lo <= 4'h0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      maint         <= VCIC_ZERO8;           // R2
      bus_st        <= VCIC_BUS_IDLE;
      reg_rdata_o   <= VCIC_ZERO32;
      reg_ack_o     <= 1'b0;
      virq_o        <= 1'b0;
      vfiq_o        <= 1'b0;
      hp_intid_o    <= 10'h000;
      hp_valid_o    <= 1'b0;
      prio_drop_o   <= 1'b0;
      deactivate_o  <= 1'b0;
      deact_intid_o <= 10'h000;
      maint_irq_o   <= 1'b0;
      pending_map_o <= '0;
    end
    else
    begin
      maint         <= next_maint;           // R1
      // R23: only with the hypervisor enable and a status bit up
      maint_irq_o   <= hyp_enable_i && (|maint);
      reg_ack_o     <= bus_go;
      if (bus_go && !reg_wr_i)
        reg_rdata_o <= rd_mux;
      bus_st        <= bus_go ? VCIC_BUS_RESP : VCIC_BUS_IDLE;
      virq_o        <= next_virq;
      vfiq_o        <= next_vfiq;
      hp_valid_o    <= best_v;
      hp_intid_o    <= best_v ? next_hp : 10'h000;
      prio_drop_o   <= guest_eoi_i;          // R9
      deactivate_o  <= next_deact;           // R9
      deact_intid_o <= guest_intid_i;
      pending_map_o <= pend;                 // R3
    end
  end

endmodule : vcic_ctrl

// [vcic_ctrl_assertions.sv]
`timescale 1ns/1ps
module vcic_ctrl_assertions
  import vcic_pkg::*;
(
  // watched ports
  input wire logic                              clk_i,
  input wire logic                              rst_i,
  input wire logic                              reg_sel_i,
  input wire logic                              reg_wr_i,
  input wire logic [15:0]                       reg_addr_i,
  input wire logic [31:0]                       reg_rdata_o,
  input wire logic                              reg_ack_o,
  input wire logic                              guest_eoi_i,
  input wire logic [vcic_pkg::VCIC_LIST_N-1:0]  eoi_status_i,
  input wire logic [7:1]                        maint_other_i,
  input wire logic                              hyp_enable_i,
  input wire logic                              virq_o,
  input wire logic                              vfiq_o,
  input wire logic                              hp_valid_o,
  input wire logic                              prio_drop_o,
  input wire logic                              maint_irq_o,
  input wire logic [vcic_pkg::VCIC_LIST_N-1:0]  pending_map_o
);
  // ***********************************
  // checks
  // ***********************************
  logic [1:0] up;
  wire        rd_take = reg_sel_i && !reg_wr_i && !reg_ack_o;

  // history from before reset must not reach the checks
  always_ff @(posedge clk_i)
    if (rst_i) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_PULSE: assert property (reg_sel_i && !reg_ack_o |=> reg_ack_o ##1 !reg_ack_o)
    else $error("ack is not a one-cycle pulse");
  AST_TYPE_VALUE: assert property (rd_take && reg_addr_i == VCIC_OFS_TYPE
    |=> reg_rdata_o == 32'h9000_0003) else $error("type register value wrong");
  AST_MAINT_EOI: assert property (up == 2'h3 && rd_take && reg_addr_i == VCIC_OFS_MAINT
    && $stable(eoi_status_i) |=> reg_rdata_o[0] == |$past(eoi_status_i)
    && reg_rdata_o[31:8] == 24'h0) else $error("maintenance eoi flag wrong");
  AST_MAINT_IRQ: assert property (up == 2'h3 |-> maint_irq_o ==
    (|$past({maint_other_i, |eoi_status_i}, 2) && $past(hyp_enable_i)))
    else $error("maintenance interrupt level wrong");
  AST_PEND_QUIET: assert property (pending_map_o == '0
    |-> !virq_o && !vfiq_o && !hp_valid_o) else $error("signal with nothing pending");
  AST_DROP: assert property (guest_eoi_i |=> prio_drop_o)
    else $error("no priority drop after eoi");
  AST_DROP_CAUSE: assert property (!guest_eoi_i |=> !prio_drop_o)
    else $error("priority drop without eoi");
  AST_VMC_RSV: assert property (rd_take && reg_addr_i == VCIC_OFS_VMC
    |=> reg_rdata_o[17:10] == 8'h00 && reg_rdata_o[8:5] == 4'h0)
    else $error("control reserved bits not zero");
endmodule : vcic_ctrl_assertions

bind vcic_ctrl vcic_ctrl_assertions vcic_ctrl_assertions_inst (.clk_i, .rst_i, .reg_sel_i,
  .reg_wr_i, .reg_addr_i, .reg_rdata_o, .reg_ack_o, .guest_eoi_i, .eoi_status_i,
  .maint_other_i, .hyp_enable_i, .virq_o, .vfiq_o, .hp_valid_o, .prio_drop_o, .maint_irq_o,
  .pending_map_o);

// [vcic_host_model.sv]
`timescale 1ns/1ps
module vcic_host_model (
  // register port
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdata_i,
  output logic             sel_o,
  output logic             wr_o,
  output logic [15:0]      addr_o,
  output logic [31:0]      wdata_o
);
  // ***********************************
  // hypervisor access
  // ***********************************
  initial
  begin
    sel_o = 1'h0;
    wr_o = 1'h0;
    addr_o = 16'h0000;
    wdata_o = 32'h0000_0000;
  end

  // memory-mapped access only; system-register path assumed off
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic ok);
    ok = 1'h0;
    @(posedge clk_i);
    sel_o <= 1'h1;
    wr_o <= w;
    addr_o <= a;
    wdata_o <= d;
    for (int n = 0; n < 8 && !ok; n++)
    begin
      @(posedge clk_i);
      ok = (ack_i === 1'h1);
    end
    q = rdata_i;
    sel_o <= 1'h0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask : bus
endmodule : vcic_host_model

// [tb_virtual_cpu_if_control_regs.sv]
`timescale 1ns/1ps
module tb_virtual_cpu_if_control_regs;
  import vcic_pkg::*;
  logic        clk_i = 1'h0, rst_i = 1'h1, reg_sel_i, reg_wr_i, reg_ack_o, guest_eoi_i;
  logic        guest_dir_i, hyp_enable_i, virq_o, vfiq_o, hp_valid_o, prio_drop_o;
  logic        deactivate_o, maint_irq_o, ok;
  logic [15:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, q, v;
  logic [9:0]  guest_intid_i, hp_intid_o, deact_intid_o, id;
  logic [7:1]  maint_other_i;
  logic [4:0]  running_prio_i;
  logic [1:0]  k;
  logic [VCIC_LIST_N-1:0] eoi_status_i, pending_map_o;
  vcic_guest_t guest_i, g;
  vcic_entry_t entry_i [VCIC_LIST_N];
  int          bad_count = 0, checks_done = 0;

  always #12.5 clk_i = ~clk_i;

  vcic_ctrl vcic_ctrl_inst (.clk_i, .rst_i, .reg_sel_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .reg_ack_o, .guest_i, .guest_eoi_i, .guest_dir_i, .guest_intid_i, .entry_i,
    .eoi_status_i, .maint_other_i, .hyp_enable_i, .running_prio_i, .virq_o, .vfiq_o,
    .hp_intid_o, .hp_valid_o, .prio_drop_o, .deactivate_o, .deact_intid_o, .maint_irq_o,
    .pending_map_o);
  vcic_host_model vcic_host_model_inst (.clk_i, .ack_i(reg_ack_o), .rdata_i(reg_rdata_o),
    .sel_o(reg_sel_i), .wr_o(reg_wr_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));

  // ***********************************
  // helpers
  // ***********************************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rw(input logic w, input logic [15:0] a, input logic [31:0] d);
    vcic_host_model_inst.bus(w, a, d, q, ok);
    if (ok !== 1'h1)
    begin
      bad_count++;
      complete_run();
    end
  endtask : rw

  // guest write pulse; outputs are looked at mid-cycle, while they stand
  task automatic pulse(input logic dir);
    @(posedge clk_i);
    guest_intid_i <= id;
    guest_eoi_i <= !dir;
    guest_dir_i <= dir;
    @(posedge clk_i);
    guest_eoi_i <= 1'h0;
    guest_dir_i <= 1'h0;
    @(negedge clk_i);
  endtask : pulse

  // ***********************************
  // scenarios
  // ***********************************
  initial
  begin
    {guest_i, guest_eoi_i, guest_dir_i, guest_intid_i, hyp_enable_i} = '0;
    {eoi_status_i, maint_other_i} = '0;
    running_prio_i = 5'h1F;
    foreach (entry_i[i]) entry_i[i] = '0;
    v = $urandom(32'h5BE8);
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    rw(0, VCIC_OFS_MAINT, 0); check(q, 32'h0);
    rw(1, VCIC_OFS_TYPE, $urandom);
    rw(1, VCIC_OFS_MAINT, 32'hFFFF_FFFF);
    rw(0, VCIC_OFS_TYPE, 0); check(q, 32'h9000_0003);
    rw(0, VCIC_OFS_MAINT, 0); check(q, 32'h0);
    rw(0, 16'h000C, 0); check(q, 32'h0);
    repeat (4)
    begin
      v = $urandom;
      rw(1, VCIC_OFS_VMC, v);
      rw(0, VCIC_OFS_VMC, 0); check(q, v & 32'hFFFC_021F);
      g = vcic_guest_t'(v[23:0]);
      {g.pmr_we, g.bpr_we, g.abpr_we, g.ctl_we} = 4'hF;
      @(posedge clk_i);
      guest_i <= g;
      @(posedge clk_i);
      guest_i <= '0;
      rw(0, VCIC_OFS_VMC, 0);
      check(q, {g.pmr, g.bpr, g.abpr, 8'h00, g.eoi_mode, 4'h0, g.cbpr, g.fiq_en,
                g.ack_ctl, g.grp1_en, g.grp0_en});
      eoi_status_i <= v[3:0];
      maint_other_i <= v[10:4];
      hyp_enable_i <= v[11];
      repeat (2) @(posedge clk_i);
      rw(0, VCIC_OFS_MAINT, 0); check(q, {24'h0, v[10:4], |v[3:0]});
      check(maint_irq_o, v[11] && |v[10:0]);
    end
    for (int i = 0; i < 4; i++)
    begin
      k = i[1:0];
      id = 10'($urandom % 1000);
      rw(1, VCIC_OFS_VMC, 32'hFF00_0003 | (k[1] ? 32'hC : 32'h0));
      entry_i[0] <= '{VCIC_ST_PENDING, k[0], 5'h03, id};
      entry_i[1] <= '{VCIC_ST_ACT_PEND, k[0], 5'h01, id ^ 10'h1};
      repeat (2) @(posedge clk_i);
      check({pending_map_o, hp_valid_o, vfiq_o, virq_o, hp_intid_o}, {4'h1, 1'h1,
            !k[0] && k[1], k[0] || !k[1], (k[0] && !k[1]) ? 10'h3FE : id});
    end
    for (int b = 0; b < 3; b++)
    begin
      rw(1, VCIC_OFS_VMC, b == 0 ? 32'h1800_0003 : b == 1 ? 32'h1900_0003 : 32'hFF00_0001);
      repeat (2) @(posedge clk_i);
      check({vfiq_o, virq_o}, {1'h0, b == 1});
    end
    // group 1 entry at 0x18 against running 0x20: binary point 5 hides the gap
    running_prio_i <= 5'h04;
    for (int c = 0; c < 4; c++)
    begin
      rw(1, VCIC_OFS_VMC, c == 0 ? 32'hFF14_0003 : c == 1 ? 32'hFFA0_0003 :
                          c == 2 ? 32'hFFA0_0013 : 32'hFF14_0013);
      repeat (2) @(posedge clk_i);
      check({vfiq_o, virq_o}, {1'h0, c[0]});
    end
    for (int m = 0; m < 2; m++)
    begin
      rw(1, VCIC_OFS_VMC, m ? 32'hFF00_0203 : 32'hFF00_0003);
      pulse(1'h0); check({prio_drop_o, deactivate_o}, {1'h1, m == 0});
      if (m) pulse(1'h1);
      check({deactivate_o, deact_intid_o}, {1'h1, id});
    end
    complete_run();
  end
endmodule : tb_virtual_cpu_if_control_regs
